// [inc/dpc_defines.svh]
// Register indices, field positions, reset values and timing counts of the pin controller.
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

`define DPC_ADDR_W        5
`define DPC_DATA_W        16
`define DPC_SUB_BIT       4

`define DPC_IDX_GPIO      4'h0
`define DPC_IDX_PROCESSOR_MODE_STATUS      4'h1
`define DPC_IDX_FLAG      4'h2
`define DPC_IDX_IEN       4'h3
`define DPC_IDX_IST       4'h4
`define DPC_IDX_ICLR      4'h5
`define DPC_IDX_GMASK     4'h6
`define DPC_IDX_PINS      4'h7

`define DPC_GPIO_DIR_LSB  4
`define DPC_GPIO_TSEL_BIT 8
`define DPC_PROCESSOR_MODE_STATUS_MP_BIT   0
`define DPC_FLAG_SET_BIT  0
`define DPC_FLAG_CLR_BIT  1
`define DPC_GMASK_BIT     0
`define DPC_PINS_PPS_BIT  0
`define DPC_PINS_BRC_BIT  1
`define DPC_PINS_ROM_BIT  2
`define DPC_PINS_OFF_BIT  3

`define DPC_IRQ_NMI       0
`define DPC_IRQ_INT0      1
`define DPC_IRQ_INT1      2

`define DPC_GPIO_ROM_ENABLE_STRAP    0
`define DPC_GPIO_BRC      2
`define DPC_GPIO_MUX      3

`define DPC_RESET_VEC     16'hFF80
`define DPC_DIR_RST       4'h0
`define DPC_GMASK_RST     1'b1
`define DPC_SYNC_INIT     18'h20F0F
`define DPC_BOOT_DONE     2'h3

`endif

// [inc/dpc_pkg.sv]
// Types shared by the pin controller, its checker and its bench.
`default_nettype none
package dpc_pkg;
`include "dpc_defines.svh"

	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [`DPC_ADDR_W-1:0] addr;
		logic [`DPC_DATA_W-1:0] wdata;
	} dpc_bus_req_t;

	typedef struct packed {
		logic [3:0] gpio;
		logic       rst_n;
		logic       int1_n;
		logic       int0_n;
		logic       nmi_n;
	} dpc_sub_pins_t;

	typedef struct packed {
		logic                off_n;
		logic                ppsel;
		dpc_sub_pins_t [1:0] sub;
	} dpc_pins_t;

	typedef struct packed {
		logic [3:0] gpio_dout;
		logic [3:0] dir;
		logic       tsel;
		logic       mp;
		logic       flag;
		logic [2:0] ien;
		logic [2:0] ist;
		logic       gmask;
		logic       rom_en;
		logic [2:0] irq_prev_n;
		logic       rst_prev_n;
		logic       fetch_go;
		logic       nmi_go;
	} dpc_sub_t;

	typedef struct packed {
		dpc_sub_t [1:0]         sub;
		logic [1:0]             boot;
		logic [`DPC_DATA_W-1:0] rdata;
	} dpc_state_t;

endpackage : dpc_pkg
`default_nettype wire

// [rtl/dpc_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module dpc_sync
	import dpc_pkg::*;
#(
	parameter int unsigned W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// Pins and filtered levels
	input  wire logic [W-1:0] pin_d,
	output logic      [W-1:0] pin_q
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] q;
	} dpc_sync_st_t;

	dpc_sync_st_t s_r;
	dpc_sync_st_t s_nxt;

	// The first stage feeds only the second; a bit moves on once two and three match.
	always_comb begin
		s_nxt     = s_r;
		s_nxt.ff1 = pin_d;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		s_nxt.q   = (s_r.ff2 & ~(s_r.ff2 ^ s_r.ff3)) | (s_r.q & (s_r.ff2 ^ s_r.ff3));
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r <= {INIT, INIT, INIT, INIT};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin_q = s_r.q;

endmodule : dpc_sync
`default_nettype wire

// [rtl/dpc_pin_ctrl.sv]
// Pin control for two processor subsystems: straps, reset, interrupts, flag and GPIO.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.svh"
// Contract
// - NMI ignores global mask and mask register, and raises a trap.
// - Reset pin halts and reinitialises; on release fetching starts at FF80.
// - Strap low selects host-port mode, high selects external-memory mode.
// - During reset the strap level seeds the microprocessor mode bit.
// - Software flag is an output-only latched bit, set bit-wise by software.
// - Flag pins float while the global output-disable input is low.
// - With the strap high, ROM-enable straps decide on-chip ROM after reset.
// - An output GPIO drives the level last written to its register bit.
// - Reading the GPIO register returns the states of input pins.
// - Each GPIO direction comes from its bit of the direction field.
// - GPIO2 as input is the branch-condition input.
// - Without branch use, GPIO2 is an ordinary readable input.
// - Host-port mode with host mux select 0 lets GPIO3 follow the register.
// - Timer-output select 1 drives the timer output on GPIO3.
// - Timer-output select 0 makes GPIO3 an ordinary GPIO.
// - Strap high makes GPIO3 the I/O-space strobe during I/O accesses.
// - INT0 is gated by mask register and global mask; INT1 is polled and cleared.
module dpc_pin_ctrl
	import dpc_pkg::*;
(
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	// Register port
	input  wire dpc_bus_req_t           bus_req,
	output logic      [`DPC_DATA_W-1:0] bus_rdata,
	// Board straps and global pins
	input  wire logic                   parallel_port_select,
	input  wire logic                   off_n,
	// Per-subsystem board pins, index 0 is A and 1 is B
	input  wire logic [1:0]             nmi_n,
	input  wire logic [1:0]             int0_n,
	input  wire logic [1:0]             int1_n,
	input  wire logic [1:0]             reset_pin_n,
	input  wire logic [1:0][3:0]        gpio_in,
	output logic      [1:0][3:0]        gpio_out,
	output logic      [1:0][3:0]        gpio_oe,
	output logic      [1:0]             software_flag_out,
	output logic      [1:0]             software_flag_oe,
	// Per-subsystem core side
	input  wire logic [1:0]             host_mux_select,
	input  wire logic [1:0]             timer_out,
	input  wire logic [1:0]             io_access,
	output logic      [1:0]             core_reset_n,
	output logic      [1:0]             fetch_start,
	output logic      [`DPC_DATA_W-1:0] fetch_addr,
	output logic      [1:0]             branch_condition_input,
	output logic      [1:0]             irq,
	output logic      [1:0]             nmi_trap,
	output logic      [1:0]             microprocessor_mode_bit,
	output logic      [1:0]             rom_enabled,
	// Port mode
	output logic                        host_port_mode,
	output logic                        external_memory_mode
);

	////////////////////////////////////////////////////////////////////////////////

	dpc_state_t s_r;
	dpc_state_t s_nxt;
	logic [17:0] sync_q;
	dpc_pins_t   py;

	function automatic logic reg_hit(
		input logic [`DPC_ADDR_W-1:0] a,
		input logic                   sub,
		input logic [3:0]             idx
	);
		return (a[`DPC_SUB_BIT] == sub) && (a[3:0] == idx);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////////////

	// Reset image of one subsystem; the straps are reloaded on every cycle of the hold.
	function automatic dpc_sub_t sub_reinit(
		input dpc_sub_t cur,
		input logic     strap,
		input logic     rom_pin
	);
		dpc_sub_t v;
		v           = cur;
		v.gpio_dout = '0;
		v.dir       = `DPC_DIR_RST;
		v.tsel      = 1'b0;
		v.flag      = 1'b0;
		v.ien       = '0;
		v.ist       = '0;
		v.gmask     = `DPC_GMASK_RST;
		v.mp        = strap;
		v.rom_en    = strap & rom_pin;
		return v;
	endfunction : sub_reinit

	// Applies one register write to a running subsystem; the clear register is handled apart.
	function automatic dpc_sub_t sub_write(
		input dpc_sub_t               cur,
		input logic [3:0]             idx,
		input logic [`DPC_DATA_W-1:0] wd
	);
		dpc_sub_t v;
		v = cur;
		unique case (idx)
			`DPC_IDX_GPIO: begin
				v.gpio_dout = wd[3:0];
				v.dir       = wd[`DPC_GPIO_DIR_LSB +: 4];
				v.tsel      = wd[`DPC_GPIO_TSEL_BIT];
			end
			`DPC_IDX_PROCESSOR_MODE_STATUS: begin
				v.mp = wd[`DPC_PROCESSOR_MODE_STATUS_MP_BIT];
			end
			`DPC_IDX_FLAG: begin
				if (wd[`DPC_FLAG_SET_BIT]) begin
					v.flag = 1'b1;
				end else if (wd[`DPC_FLAG_CLR_BIT]) begin
					v.flag = 1'b0;
				end
			end
			`DPC_IDX_IEN: begin
				v.ien = wd[2:0];
			end
			`DPC_IDX_GMASK: begin
				v.gmask = wd[`DPC_GMASK_BIT];
			end
			default: begin
				v = cur;
			end
		endcase
		return v;
	endfunction : sub_write

	// GPIO3 priority: I/O strobe in memory mode, then timer, then register, else released.
	// Returns level and enable; the mux inputs pass straight through to the pin.
	function automatic logic [1:0] gpio3_drive(
		input logic strap,
		input logic out_on,
		input logic tsel,
		input logic hmux,
		input logic tmr,
		input logic ioa,
		input logic dout,
		input logic dir
	);
		logic [1:0] d;
		d = 2'h0;
		if (strap) begin
			// I/O strobe
			// The strobe floats with the other memory-control pins while outputs are off.
			d = {!ioa, out_on};
		end else if (tsel) begin
			d = {tmr, 1'b1};
		end else if (!hmux) begin
			d = {dout, dir};
		end
		return d;
	endfunction : gpio3_drive

	// plain input read
	// One register word of a subsystem; unmapped indices and the clear register read zero.
	function automatic logic [`DPC_DATA_W-1:0] read_word(
		input dpc_sub_t   st,
		input logic [3:0] idx,
		input logic [3:0] pins,
		input logic       strap,
		input logic       brc,
		input logic       off
	);
		logic [`DPC_DATA_W-1:0] w;
		w = '0;
		unique case (idx)
			`DPC_IDX_GPIO: begin
				// Output pins read their latched data, input pins their synchronised level.
				w[3:0]                    = (st.dir & st.gpio_dout) | (~st.dir & pins);
				w[`DPC_GPIO_DIR_LSB +: 4] = st.dir;
				w[`DPC_GPIO_TSEL_BIT]     = st.tsel;
			end
			`DPC_IDX_PROCESSOR_MODE_STATUS: begin
				w[`DPC_PROCESSOR_MODE_STATUS_MP_BIT] = st.mp;
			end
			`DPC_IDX_FLAG: begin
				w[`DPC_FLAG_SET_BIT] = st.flag;
			end
			`DPC_IDX_IEN: begin
				w[2:0] = st.ien;
			end
			`DPC_IDX_IST: begin
				w[2:0] = st.ist;
			end
			`DPC_IDX_GMASK: begin
				w[`DPC_GMASK_BIT] = st.gmask;
			end
			`DPC_IDX_PINS: begin
				// The branch condition reads zero while GPIO2 is an output.
				w[`DPC_PINS_PPS_BIT] = strap;
				w[`DPC_PINS_BRC_BIT] = brc;
				w[`DPC_PINS_ROM_BIT] = st.rom_en;
				w[`DPC_PINS_OFF_BIT] = off;
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction : read_word

	// Every board pin is asynchronous, including both straps.
	dpc_sync #(
		.W    (18),
		.INIT (`DPC_SYNC_INIT)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_d   ({off_n, parallel_port_select,
			gpio_in[1], reset_pin_n[1], int1_n[1], int0_n[1], nmi_n[1],
			gpio_in[0], reset_pin_n[0], int1_n[0], int0_n[0], nmi_n[0]}),
		.pin_q   (sync_q)
	);

	assign py = dpc_pins_t'(sync_q);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [2:0]             cur_n;
		logic [2:0]             ev;
		logic [2:0]             clr;
		logic                   in_rst;
		logic                   sub;
		logic [`DPC_DATA_W-1:0] wd;
		cur_n   = '0;
		ev      = '0;
		clr     = '0;
		in_rst  = 1'b0;
		sub     = 1'b0;
		wd      = bus_req.wdata;
		s_nxt       = s_r;
		s_nxt.rdata = '0;
		// Sub resets hold for three cycles after system reset; the synchronised pins settle one cycle later.
		if (s_r.boot != `DPC_BOOT_DONE) begin
			s_nxt.boot = s_r.boot + 2'h1;
		end
		for (int i = 0; i < 2; i++) begin
			sub    = i[0];
			// Clear strobes are per subsystem; one copy must never clear the other.
			clr    = '0;
			cur_n  = {py.sub[i].int1_n, py.sub[i].int0_n, py.sub[i].nmi_n};
			in_rst = !py.sub[i].rst_n || (s_r.boot != `DPC_BOOT_DONE);
			ev     = s_r.sub[i].irq_prev_n & ~cur_n & {3{!in_rst}};
			s_nxt.sub[i].irq_prev_n = cur_n;
			s_nxt.sub[i].rst_prev_n = !in_rst;
			s_nxt.sub[i].fetch_go = !in_rst && !s_r.sub[i].rst_prev_n;
			s_nxt.sub[i].nmi_go = ev[`DPC_IRQ_NMI];
			if (in_rst) begin
				// A held subsystem reloads its reset image and drops pin edges.
				s_nxt.sub[i] = sub_reinit(s_nxt.sub[i], py.ppsel,
					py.sub[i].gpio[`DPC_GPIO_ROM_ENABLE_STRAP]);
			end else begin
				// Writes reach only the subsystem that the address names.
				if (bus_req.wr && (bus_req.addr[`DPC_SUB_BIT] == sub)) begin
					s_nxt.sub[i] = sub_write(s_nxt.sub[i], bus_req.addr[3:0], wd);
				end
				if (bus_req.wr && reg_hit(bus_req.addr, sub, `DPC_IDX_ICLR)) begin
					clr = wd[2:0];
				end
				s_nxt.sub[i].ist = (s_r.sub[i].ist & ~clr) | ev;
			end
			// Read data is zero unless this cycle reads; the port never stalls.
			if (bus_req.rd && (bus_req.addr[`DPC_SUB_BIT] == sub)) begin
				s_nxt.rdata = read_word(s_r.sub[i], bus_req.addr[3:0], py.sub[i].gpio,
					py.ppsel, branch_condition_input[i], py.off_n);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign bus_rdata  = s_r.rdata;
	assign fetch_addr = `DPC_RESET_VEC;

	assign host_port_mode       = !py.ppsel;
	assign external_memory_mode = py.ppsel;

	for (genvar g = 0; g < 2; g++) begin : g_sub
		assign core_reset_n[g]            = s_r.sub[g].rst_prev_n;
		assign fetch_start[g]             = s_r.sub[g].fetch_go;
		assign nmi_trap[g]                = s_r.sub[g].nmi_go;
		assign microprocessor_mode_bit[g] = s_r.sub[g].mp;
		assign rom_enabled[g]             = s_r.sub[g].rom_en;
		// INT1 status never reaches irq; software polls and clears it.
		// NMI unmasked
		assign irq[g] = s_r.sub[g].ist[`DPC_IRQ_NMI] |
			(!s_r.sub[g].gmask & s_r.sub[g].ist[`DPC_IRQ_INT0] &
			s_r.sub[g].ien[`DPC_IRQ_INT0]);
		assign branch_condition_input[g] = !s_r.sub[g].dir[`DPC_GPIO_BRC] &
			py.sub[g].gpio[`DPC_GPIO_BRC];
		assign software_flag_out[g] = s_r.sub[g].flag;
		assign software_flag_oe[g]  = py.off_n;
		for (genvar b = 0; b < `DPC_GPIO_MUX; b++) begin : g_bit
			assign gpio_out[g][b] = s_r.sub[g].gpio_dout[b];
			assign gpio_oe[g][b]  = s_r.sub[g].dir[b];
		end
		// GPIO3 shares the pin between strobe, timer and register.
		assign {gpio_out[g][`DPC_GPIO_MUX], gpio_oe[g][`DPC_GPIO_MUX]} = gpio3_drive(py.ppsel,
			py.off_n, s_r.sub[g].tsel, host_mux_select[g], timer_out[g], io_access[g],
			s_r.sub[g].gpio_dout[`DPC_GPIO_MUX], s_r.sub[g].dir[`DPC_GPIO_MUX]);
	end

endmodule : dpc_pin_ctrl
`default_nettype wire

// [bench/dpc_pin_checker.sv]
// Concurrent checks on the pin controller's ports.
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_checker
	import dpc_pkg::*;
(
	// Clock and reset
	input wire logic             sys_clk,
	input wire logic             rst_n,
	// Register port
	input wire dpc_bus_req_t     bus_req,
	input wire logic [15:0]      bus_rdata,
	// Board pins
	input wire logic             parallel_port_select,
	input wire logic             off_n,
	input wire logic [1:0]       reset_pin_n,
	input wire logic [1:0][3:0]  gpio_out,
	input wire logic [1:0][3:0]  gpio_oe,
	input wire logic [1:0]       software_flag_oe,
	// Core side
	input wire logic [1:0]       io_access,
	input wire logic [1:0]       core_reset_n,
	input wire logic [1:0]       fetch_start,
	input wire logic [15:0]      fetch_addr,
	input wire logic [1:0]       branch_condition_input,
	input wire logic [1:0]       irq,
	input wire logic [1:0]       nmi_trap,
	input wire logic [1:0]       microprocessor_mode_bit,
	input wire logic             host_port_mode,
	input wire logic             external_memory_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	fetch_addr_a: assert property (fetch_addr == 16'hFF80)
		else $error("fetch address wrong");
	fetch_pulse_a: assert property (fetch_start[0] |-> core_reset_n[0] && !$past(core_reset_n[0]))
		else $error("fetch start not at reset exit");
	core_hold_a: assert property (!reset_pin_n[0] [*7] |-> !core_reset_n[0])
		else $error("core runs while reset pin low");
	nmi_irq_a: assert property (nmi_trap[0] |-> irq[0] ##1 !nmi_trap[0])
		else $error("nmi trap without irq or too long");
	flag_off_a: assert property (!off_n [*7] |-> software_flag_oe == 2'b00)
		else $error("flag driven while outputs disabled");
	port_mode_a: assert property ($stable(parallel_port_select) [*7] |->
		external_memory_mode == parallel_port_select && host_port_mode == !parallel_port_select)
		else $error("port mode does not follow strap");
	io_strobe_a: assert property (external_memory_mode |->
		gpio_out[0][3] == !io_access[0] && gpio_out[1][3] == !io_access[1])
		else $error("gpio3 not io strobe");
	branch_out_a: assert property (gpio_oe[0][2] [*2] |-> !branch_condition_input[0])
		else $error("branch condition from output pin");
	rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
		else $error("read data without read");
	mp_seed_a: assert property ((!reset_pin_n[0] && $stable(parallel_port_select)) [*7] |->
		microprocessor_mode_bit[0] == parallel_port_select)
		else $error("mode bit not seeded from strap");
endmodule : dpc_pin_checker

bind dpc_pin_ctrl dpc_pin_checker u_chk (.sys_clk, .rst_n, .bus_req, .bus_rdata,
	.parallel_port_select, .off_n, .reset_pin_n, .gpio_out, .gpio_oe, .software_flag_oe,
	.io_access, .core_reset_n, .fetch_start, .fetch_addr, .branch_condition_input, .irq,
	.nmi_trap, .microprocessor_mode_bit, .host_port_mode, .external_memory_mode);
`default_nettype wire

// [bench/dpc_board.sv]
// Board logic driving the straps, reset, interrupt and gpio pins.
`timescale 1ns/1ps
`default_nettype none
module dpc_board (
	// Clock and bus activity
	input wire logic        sys_clk,
	input wire logic        bus_busy,
	// Pins
	output logic            ppsel,
	output logic            off_n,
	output logic [1:0]      nmi_n,
	output logic [1:0]      int0_n,
	output logic [1:0]      int1_n,
	output logic [1:0]      rpin_n,
	output logic [1:0][3:0] gpio
);
	initial begin
		ppsel = 1'b0;
		off_n = 1'b1;
		{nmi_n, int0_n, int1_n, rpin_n} = '1;
		gpio = '0;
	end
	// Low for three cycles so the edge clears the agree filter.
	task pulse(input int k, input int s);
		@(posedge sys_clk);
		if (k == 0) nmi_n[s] <= 1'b0;
		else if (k == 1) int0_n[s] <= 1'b0;
		else int1_n[s] <= 1'b0;
		repeat (3) @(posedge sys_clk);
		{nmi_n, int0_n, int1_n} <= '1;
	endtask : pulse
	task strap(input logic v);
		@(posedge sys_clk);
		while (bus_busy) @(posedge sys_clk);
		ppsel <= v;
	endtask : strap
endmodule : dpc_board
`default_nettype wire

// [bench/dpc_pin_ctrl_tb.sv]
// Self-checking bench for the two-subsystem pin controller.
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_ctrl_tb
	import dpc_pkg::*;
;
	logic             sys_clk;
	logic             rst_n;
	dpc_bus_req_t     bus_req;
	logic [15:0]      bus_rdata, faddr;
	logic             ppsel, off_n, hpm, emm;
	logic [1:0]       nmi_n, int0_n, int1_n, rpin_n, hmux, tmr, ioa;
	logic [1:0]       flag, flag_oe, crst_n, fst, brc, irq, trap, mp, rom;
	logic [1:0][3:0]  gin, gout, goe, brd;
	int               n_errors, checks_done, cyc;

	// A driven pin reads back what the device drives, else the board level.
	assign gin = (goe & gout) | (~goe & brd);

	dpc_pin_ctrl u_dpc_pin_ctrl (.sys_clk, .rst_n, .bus_req, .bus_rdata,
		.parallel_port_select(ppsel), .off_n, .nmi_n, .int0_n, .int1_n, .reset_pin_n(rpin_n),
		.gpio_in(gin), .gpio_out(gout), .gpio_oe(goe), .software_flag_out(flag),
		.software_flag_oe(flag_oe), .host_mux_select(hmux), .timer_out(tmr), .io_access(ioa),
		.core_reset_n(crst_n), .fetch_start(fst), .fetch_addr(faddr),
		.branch_condition_input(brc), .irq, .nmi_trap(trap), .microprocessor_mode_bit(mp),
		.rom_enabled(rom), .host_port_mode(hpm), .external_memory_mode(emm));
	dpc_board u_board (.sys_clk, .bus_busy(bus_req.wr | bus_req.rd), .ppsel, .off_n, .nmi_n,
		.int0_n, .int1_n, .rpin_n, .gpio(brd));

	////////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge sys_clk) bus_req <= {1'b1, 1'b0, a, v};
		@(posedge sys_clk) bus_req <= '0;
		@(negedge sys_clk);
	endtask : wr
	task rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge sys_clk) bus_req <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge sys_clk) bus_req <= '0;
		@(negedge sys_clk) chk("read data", bus_rdata & m, e);
	endtask : rc
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : wt
	task print_verdict;
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	task t_boot;
		for (int k = 0; k < 20 && fst !== 2'b11; k++) @(negedge sys_clk);
		chk("fetch start", fst, 16'h0003);
		chk("fetch addr", faddr, 16'hFF80);
		rc(5'h06, 16'hFFFF, 16'h0001);
		rc(5'h01, 16'h0001, 16'h0000);
	endtask : t_boot
	task t_gpio;
		wr(5'h00, 16'h00F5);
		chk("gpio out", gout[0], 16'h0005);
		chk("gpio oe", goe[0], 16'h000F);
		rc(5'h00, 16'h000F, 16'h0005);
		wr(5'h10, 16'h0030);
		chk("gpio oe b", {goe[1], goe[0]}, 16'h003F);
		wr(5'h00, 16'h0000);
		@(posedge sys_clk) u_board.gpio[0] <= 4'h6;
		wt(8);
		rc(5'h00, 16'h000F, 16'h0006);
		chk("branch", brc[0], 16'h0001);
		rc(5'h07, 16'h0002, 16'h0002);
		wr(5'h00, 16'h0088);
		chk("gpio3 reg", {gout[0][3], goe[0][3]}, 16'h0003);
		@(posedge sys_clk) hmux <= 2'b01;
		wt(0);
		chk("gpio3 hmux", goe[0][3], 16'h0000);
		@(posedge sys_clk) hmux <= 2'b00;
		wr(5'h00, 16'h0100);
		@(posedge sys_clk) tmr <= 2'b01;
		wt(0);
		chk("gpio3 timer", {gout[0][3], goe[0][3]}, 16'h0003);
	endtask : t_gpio
	task t_flag;
		wr(5'h02, 16'h0001);
		chk("flag", flag[0], 16'h0001);
		wr(5'h02, 16'h0002);
		rc(5'h02, 16'h0001, 16'h0000);
		@(posedge sys_clk) u_board.off_n <= 1'b0;
		wt(8);
		chk("flag oe", flag_oe, 16'h0000);
		@(posedge sys_clk) u_board.off_n <= 1'b1;
		wt(8);
		chk("flag oe", flag_oe, 16'h0003);
	endtask : t_flag
	task t_irq;
		u_board.pulse(0, 0);
		for (int k = 0; k < 20 && trap[0] !== 1'b1; k++) @(negedge sys_clk);
		chk("nmi irq", {trap[0], irq[0]}, 16'h0003);
		wr(5'h05, 16'h0001);
		chk("irq clr", irq[0], 16'h0000);
		wr(5'h03, 16'h0002);
		u_board.pulse(1, 0);
		wt(8);
		chk("int0 masked", irq[0], 16'h0000);
		wr(5'h06, 16'h0000);
		chk("int0 irq", irq[0], 16'h0001);
		wr(5'h05, 16'h0002);
		u_board.pulse(2, 0);
		wt(8);
		rc(5'h04, 16'h0007, 16'h0004);
		chk("int1 polled", irq[0], 16'h0000);
		u_board.pulse(2, 1);
		wt(8);
		wr(5'h05, 16'h0004);
		rc(5'h04, 16'h0007, 16'h0000);
		rc(5'h14, 16'h0007, 16'h0004);
		rc(5'h0F, 16'hFFFF, 16'h0000);
	endtask : t_irq
	task t_strap;
		u_board.strap(1'b1);
		u_board.gpio[0] <= 4'h1;
		@(posedge sys_clk) u_board.rpin_n[0] <= 1'b0;
		wt(8);
		chk("held core", crst_n[0], 16'h0000);
		chk("mode bit", mp[0], 16'h0001);
		@(posedge sys_clk) u_board.rpin_n[0] <= 1'b1;
		for (int k = 0; k < 20 && fst[0] !== 1'b1; k++) @(negedge sys_clk);
		chk("rom en", {fst[0], rom[0]}, 16'h0003);
		chk("modes", {emm, hpm}, 16'h0002);
		@(posedge sys_clk) ioa <= 2'b01;
		wt(0);
		chk("io strobe", gout[0][3], 16'h0000);
	endtask : t_strap

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Every test together needs well under a thousand cycles.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict;
		end
	end
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		{hmux, tmr, ioa} = '0;
		{n_errors, checks_done, cyc} = '0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_boot;
		t_gpio;
		t_flag;
		t_irq;
		t_strap;
		print_verdict;
	end
endmodule : dpc_pin_ctrl_tb
`default_nettype wire
